// File: core/halt_release_ctrl.sv
`timescale 1ns/1ps
`include "halt_release_defs.svh"
// Functional notes
// R01 - Operand 0010B enables periodic carry as halt release
// R02 - Carry release: leave halt at once when carry flag is set
// R03 - Carry flip-flop is visible directly as the carry status flag
// R04 - Carry sets every 1, 5, 100 or 250 ms as software selects
// R05 - Operand 1000B enables interrupt acceptance as halt release
// R06 - Leave halt on acceptance, not on a mere request
// R07 - Six sources may release halt
// R08 - Accept only with request, global enable and source permit set
// R09 - Request without all enables is not accepted; stay halted
// R10 - Interrupt release jumps to the source vector address
// R11 - Saved return address is the instruction after halt
// R12 - Pin zero beats basic timer 1 when simultaneous
// R13 - Pending enabled request is taken after return before next instruction
// R14 - Request flag change just before halt is not seen by that halt
// R15 - Software puts a no-operation between flag change and halt
// R16 - Any one enabled condition ends halt
// R17 - Operand 0000B: only reset ends halt
// R18 - Halt stops CPU clock; peripherals keep running
// R19 - Non-interrupt release resumes after the halt instruction
// R20 - Condition already true at halt: exit next cycle
// R21 - Release conditions latched at halt and held throughout
module halt_release_ctrl
    import halt_release_pkg::*;
(
    input  wire logic     SYS_CLK,        // 40 MHz clock
    input  wire logic     RST_B,          // Power-on or chip-enable reset
    input  wire logic     HALT_EXEC,      // Halt instruction executes, pulse
    input  wire logic [3:0] HALT_OPERAND, // Halt operand h
    input  wire addr_t    NEXT_PC,        // Address after the halt instruction
    input  wire logic     SVC_RETURN,     // Return from service executes, pulse
    input  wire logic     CARRY_SEL_HI,   // Carry interval select high
    input  wire logic     CARRY_SEL_LO,   // Carry interval select low
    input  wire logic     CARRY_FLAG_CLR, // Carry flag read-and-clear, pulse
    input  wire logic     GIE,            // Global interrupt enable
    input  wire src_vec_t SRC_REQ,        // Source request flags
    input  wire src_vec_t SRC_PERMIT,     // Source permit flags
    output logic          CPU_CLK_EN,     // CPU clock enable, low in halt
    output logic          CARRY_FLAG,     // Periodic carry flag
    output logic          HALTED,         // Halt state
    output logic          IRQ_TAKE,       // Interrupt accepted, pulse
    output addr_t         IRQ_VECTOR,     // Vector of accepted source
    output src_vec_t      IRQ_ACK,        // Source acknowledge, clears request
    output addr_t         RET_ADDR,       // Saved return address
    output logic          RESUME,         // Carry release or return from service, pulse
    output addr_t         RESUME_PC       // Address to resume at
);
    localparam int unsigned CYC_A = `HR_CYC(`HR_IVL_A_MS);
    localparam int unsigned CYC_B = `HR_CYC(`HR_IVL_B_MS);
    localparam int unsigned CYC_C = `HR_CYC(`HR_IVL_C_MS);
    localparam int unsigned CYC_D = `HR_CYC(`HR_IVL_D_MS);

    // Interval length from select bits
    function automatic logic [23:0] ivl_len(input logic hi, input logic lo);
        case ({hi, lo})
            2'b11:   ivl_len = 24'(CYC_A);
            2'b10:   ivl_len = 24'(CYC_B);
            2'b01:   ivl_len = 24'(CYC_C);
            default: ivl_len = 24'(CYC_D);
        endcase
    endfunction : ivl_len

    irq_link_if link();
    src_vec_t   req_d_r;
    src_vec_t   req_d_nxt;
    src_vec_t   ack_r;
    src_vec_t   ack_nxt;

    // Sampled request flags delayed one cycle; a source being acknowledged
    // is masked until its flag has dropped, so one request is never taken twice
    // R14 delayed request view
    always_comb begin
        req_d_nxt = SRC_REQ & ~ack_nxt & ~ack_r;
    end
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            req_d_r <= '0;
        end else begin
            req_d_r <= req_d_nxt;
        end
    end

    // R07 six sources arbitrated
    irq_arbiter u_arb (
        .req    (req_d_r),
        .permit (SRC_PERMIT),
        .gie    (GIE),
        .link   (link.arb)
    );

    // Periodic carry timer
    logic [23:0] tick_cnt_r;
    logic [23:0] tick_cnt_nxt;
    logic        carry_r;
    logic        carry_nxt;
    logic        tick;
    assign tick = (tick_cnt_r >= ivl_len(CARRY_SEL_HI, CARRY_SEL_LO) - 24'h00_0001);

    // R04 interval count, set wins over clear
    always_comb begin
        tick_cnt_nxt = tick ? 24'h00_0000 : tick_cnt_r + 24'h00_0001;
        carry_nxt    = carry_r;
        if (CARRY_FLAG_CLR) begin
            carry_nxt = 1'b0;
        end
        if (tick) begin
            carry_nxt = 1'b1;
        end
    end
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            tick_cnt_r <= 24'h00_0000;
            carry_r    <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            carry_r    <= carry_nxt;
        end
    end
    // R03 flag mirrors flip-flop
    assign CARRY_FLAG = carry_r;

    // Sequencer state
    seq_state_t  st_r;
    seq_state_t  st_nxt;
    logic [3:0]  cond_r;
    logic [3:0]  cond_nxt;
    addr_t       ret_r;
    addr_t       ret_nxt;
    logic        take_r;
    logic        take_nxt;
    logic        res_r;
    logic        res_nxt;
    addr_t       vec_r;
    addr_t       vec_nxt;
    logic        carry_hit;
    logic        intr_hit;

    // R01 carry release enable
    assign carry_hit = cond_r[`HR_BIT_CARRY] & carry_r;
    // R05 R06 R09 release only on acceptance
    assign intr_hit  = cond_r[`HR_BIT_INTR] & link.any_ok;

    // Next state of the sequencer
    always_comb begin
        st_nxt   = st_r;
        cond_nxt = cond_r;
        ret_nxt  = ret_r;
        take_nxt = 1'b0;
        res_nxt  = 1'b0;
        vec_nxt  = vec_r;
        ack_nxt  = '0;
        case (st_r)
            ST_RUN: begin
                if (HALT_EXEC) begin
                    // R21 latch operand
                    cond_nxt = HALT_OPERAND;
                    ret_nxt  = NEXT_PC;
                    st_nxt   = ST_HALT;
                end
            end
            ST_HALT: begin
                // R16 R20 any enabled condition, R17 none when zero
                if (intr_hit) begin
                    // R10 R11 vector and return address
                    take_nxt = 1'b1;
                    vec_nxt  = link.vector;
                    ack_nxt  = link.grant;
                    st_nxt   = ST_SERV;
                end else if (carry_hit) begin
                    // R02 R19 resume after halt
                    res_nxt = 1'b1;
                    st_nxt  = ST_RUN;
                end
            end
            ST_SERV: begin
                // R13 pending request taken at return
                if (SVC_RETURN && link.any_ok) begin
                    take_nxt = 1'b1;
                    vec_nxt  = link.vector;
                    ack_nxt  = link.grant;
                end else if (SVC_RETURN) begin
                    res_nxt = 1'b1;
                    st_nxt  = ST_RUN;
                end
            end
            default: begin
                st_nxt = ST_RUN;
            end
        endcase
    end
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_r   <= ST_RUN;
            cond_r <= `HR_OPERAND_RESET;
            ret_r  <= 12'h0000;
            take_r <= 1'b0;
            res_r  <= 1'b0;
            vec_r  <= 12'h0000;
            ack_r  <= '0;
        end else begin
            st_r   <= st_nxt;
            cond_r <= cond_nxt;
            ret_r  <= ret_nxt;
            take_r <= take_nxt;
            res_r  <= res_nxt;
            vec_r  <= vec_nxt;
            ack_r  <= ack_nxt;
        end
    end

    // R18 CPU clock gated in halt
    assign CPU_CLK_EN = (st_r != ST_HALT);
    assign HALTED     = (st_r == ST_HALT);
    assign IRQ_TAKE   = take_r;
    assign IRQ_VECTOR = vec_r;
    assign IRQ_ACK    = ack_r;
    assign RET_ADDR   = ret_r;
    assign RESUME     = res_r;
    assign RESUME_PC  = ret_r;

    // Assertions
    // R02 carry release exit
    a_carry_release: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R02
        (HALTED && cond_r[`HR_BIT_CARRY] && carry_r && !intr_hit) |=> (RESUME && !HALTED))
        else $error("carry release missed");
    // R06 release on acceptance
    a_intr_release: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R06
        (HALTED && intr_hit) |=> (IRQ_TAKE && IRQ_VECTOR == $past(link.vector)))
        else $error("interrupt release missed");
    // R09 no enable stays
    a_no_enable_stay: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R09
        (HALTED && !GIE && !carry_hit) |=> HALTED)
        else $error("left halt without enable");
    // R17 empty operand holds
    a_zero_operand_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R17
        (HALTED && cond_r == 4'h0) |=> HALTED)
        else $error("zero operand left halt");
    // R12 pin zero first
    a_pin0_priority: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R12
        (HALTED && intr_hit && link.grant[0]) |=> (IRQ_VECTOR == `HR_VEC_PIN0))
        else $error("pin zero not first");
    // R11 return address saved
    a_ret_addr_kept: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R11
        (st_r == ST_RUN && HALT_EXEC) |=> (RET_ADDR == $past(NEXT_PC)))
        else $error("return address wrong");
    // R21 conditions held
    a_cond_held: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R21
        (HALTED && $past(HALTED)) |-> $stable(cond_r))
        else $error("condition changed in halt");
    // R03 carry flag visible
    a_carry_visible: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R03
        tick |=> CARRY_FLAG)
        else $error("carry flag not set");
    // R18 clock stopped
    a_clk_stopped: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R18
        (st_r == ST_RUN && HALT_EXEC) |=> !CPU_CLK_EN)
        else $error("clock not stopped");

    // R07 single source acknowledged
    a_ack_onehot: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R07
        IRQ_TAKE |-> $onehot(IRQ_ACK))
        else $error("acknowledge not one-hot");
    // R08 taken source enabled
    a_take_enabled: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R08
        IRQ_TAKE |-> ($past(GIE) && (($past(SRC_PERMIT) & IRQ_ACK) == IRQ_ACK)))
        else $error("interrupt taken without enables");
    // R16 any condition releases
    a_any_release: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R16
        (HALTED && (carry_hit || intr_hit)) |=> !HALTED)
        else $error("enabled condition did not release");
    // R03 clear drops flag
    a_carry_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R03
        (CARRY_FLAG_CLR && !tick) |=> !CARRY_FLAG)
        else $error("carry flag not cleared");
    // R21 halt refused when busy
    a_refuse_busy: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R21
        (st_r != ST_RUN && HALT_EXEC) |=> (RET_ADDR == $past(RET_ADDR)))
        else $error("return address moved while busy");
    // R13 pending request chained
    a_chain_take: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R13
        (st_r == ST_SERV && SVC_RETURN && link.any_ok) |=> (IRQ_TAKE && !RESUME))
        else $error("pending request not chained");
    // R11 return to halt successor
    a_resume_exit: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R11
        (st_r == ST_SERV && SVC_RETURN && !link.any_ok) |=> (RESUME && st_r == ST_RUN))
        else $error("return did not resume");
    // R01 carry needs its bit
    a_carry_gated: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R01
        (HALTED && !cond_r[`HR_BIT_CARRY] && !intr_hit) |=> HALTED)
        else $error("carry released without its bit");
    // R05 interrupt needs its bit
    a_intr_gated: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // R05
        (HALTED && !cond_r[`HR_BIT_INTR] && !carry_hit) |=> HALTED)
        else $error("interrupt released without its bit");

    c_carry_exit: cover property (@(posedge SYS_CLK) disable iff (!RST_B) HALTED ##1 RESUME);
    c_intr_exit:  cover property (@(posedge SYS_CLK) disable iff (!RST_B) HALTED ##1 IRQ_TAKE);
    c_chain_take: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
        (st_r == ST_SERV && SVC_RETURN && link.any_ok));
    c_pin0_first: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
        (HALTED && intr_hit && link.grant[0] && req_d_r[3]));
endmodule : halt_release_ctrl

// File: core/halt_release_defs.svh
`ifndef HALT_RELEASE_DEFS_SVH
`define HALT_RELEASE_DEFS_SVH

// Halt operand bit positions
`define HR_BIT_KEY         0
`define HR_BIT_CARRY       1
`define HR_BIT_INTR        3
`define HR_OPERAND_RESET   4'h0
// Carry interval figures in ms and clock rate in Hz
`define HR_CLK_HZ          40000000
`define HR_IVL_A_MS        1
`define HR_IVL_B_MS        5
`define HR_IVL_C_MS        100
`define HR_IVL_D_MS        250
// Cycles per interval, derived from rate and figure
`define HR_CYC(ms)         ((`HR_CLK_HZ / 1000) * (ms))
// Vector addresses per source, in priority order (index 0 highest)
`define HR_VEC_PIN0        12'h0006
`define HR_VEC_PIN1        12'h0005
`define HR_VEC_T12         12'h0004
`define HR_VEC_BT1         12'h0003
`define HR_VEC_SER0        12'h0002
`define HR_VEC_FCNT        12'h0001
`define HR_NUM_SRC         6

`endif

// File: core/halt_release_pkg.sv
package halt_release_pkg;
    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_HALT = 3'b010,
        ST_SERV = 3'b100
    } seq_state_t;
    typedef logic [11:0] addr_t;
    typedef logic [5:0]  src_vec_t;
endpackage : halt_release_pkg

// File: core/irq_link_if.sv
`timescale 1ns/1ps
// Interrupt arbiter results passed to the sequencer
interface irq_link_if;
    import halt_release_pkg::*;
    logic     any_ok;
    src_vec_t grant;
    addr_t    vector;
    modport arb (output any_ok, output grant, output vector);
    modport seq (input any_ok, input grant, input vector);
endinterface : irq_link_if

// File: core/irq_arbiter.sv
`timescale 1ns/1ps
`include "halt_release_defs.svh"
module irq_arbiter
    import halt_release_pkg::*;
(
    input  wire src_vec_t req,     // Source request flags
    input  wire src_vec_t permit,  // Source permit flags
    input  wire logic     gie,     // Global enable
    irq_link_if.arb       link     // Arbiter results
);
    // Pick lowest index eligible source
    function automatic src_vec_t first_one(input src_vec_t v);
        src_vec_t r;
        r = '0;
        for (int i = `HR_NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = '0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction : first_one

    src_vec_t elig;
    // R08 all three enables
    assign elig        = req & permit & {`HR_NUM_SRC{gie}};
    assign link.any_ok = |elig;
    // R12 fixed priority
    assign link.grant  = first_one(elig);

    // Vector lookup for granted source
    always_comb begin
        case (link.grant)
            6'b00_0001: link.vector = `HR_VEC_PIN0;
            6'b00_0010: link.vector = `HR_VEC_PIN1;
            6'b00_0100: link.vector = `HR_VEC_T12;
            6'b00_1000: link.vector = `HR_VEC_BT1;
            6'b01_0000: link.vector = `HR_VEC_SER0;
            6'b10_0000: link.vector = `HR_VEC_FCNT;
            default:    link.vector = 12'h0000;
        endcase
    end
endmodule : irq_arbiter

// File: verification/irq_source_model.sv
`timescale 1ns/1ps
// Six source request flags; set by raise pulses, cleared by acknowledge
module irq_source_model
    import halt_release_pkg::*;
(
    input  wire logic     sys_clk, // Clock
    input  wire logic     rst_b,   // Reset, active low
    input  wire src_vec_t raise,   // Request set pulses
    input  wire src_vec_t ack,     // Acknowledge from the block
    output src_vec_t      req      // Request flags
);
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            req <= '0;
        end else begin
            req <= (req & ~ack) | raise;
        end
    end
endmodule : irq_source_model

// File: verification/tb.sv
`timescale 1ns/1ps
`include "halt_release_defs.svh"
module tb
    import halt_release_pkg::*;
;
    logic       clk, rst_b, hx, rx, clr, gie, clk_en, cflag, halted, take, resume;
    logic [3:0] op;
    logic [1:0] sel;
    addr_t      pc, vec, ret, rpc;
    src_vec_t   permit, raise, req, ack;
    int         fail_count, total_checks, cyc, t0, t1;
    logic [31:0] seed, r;
    addr_t      vtab [6] = '{`HR_VEC_PIN0, `HR_VEC_PIN1, `HR_VEC_T12, `HR_VEC_BT1, `HR_VEC_SER0, `HR_VEC_FCNT};

    halt_release_ctrl dut (.SYS_CLK(clk), .RST_B(rst_b), .HALT_EXEC(hx), .HALT_OPERAND(op), .NEXT_PC(pc),
        .SVC_RETURN(rx), .CARRY_SEL_HI(sel[1]), .CARRY_SEL_LO(sel[0]), .CARRY_FLAG_CLR(clr), .GIE(gie),
        .SRC_REQ(req), .SRC_PERMIT(permit), .CPU_CLK_EN(clk_en), .CARRY_FLAG(cflag), .HALTED(halted),
        .IRQ_TAKE(take), .IRQ_VECTOR(vec), .IRQ_ACK(ack), .RET_ADDR(ret), .RESUME(resume), .RESUME_PC(rpc));
    irq_source_model src (.sys_clk(clk), .rst_b(rst_b), .raise(raise), .ack(ack), .req(req));

    // Clock and edge counter
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic pick(input int k);
        return (k == 0) ? take : ((k == 1) ? resume : cflag);
    endfunction : pick
    task automatic chk1(input logic g, input logic e);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %0t flag %b exp %b", $time, g, e);
        end
    endtask : chk1
    task automatic chka(input addr_t g, input addr_t e);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %0t value %h exp %h", $time, g, e);
        end
    endtask : chka
    task automatic chkn(input int g, input int e);
        total_checks++;
        if (g != e) begin
            fail_count++;
            $display("MISMATCH %0t count %0d exp %0d", $time, g, e);
        end
    endtask : chkn
    // Bounded wait: 0 take, 1 resume, 2 carry flag
    task automatic wait_on(input int k, input int lim);
        int n;
        n = 0;
        while (pick(k) !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk1(pick(k), 1'b1);
    endtask : wait_on
    task automatic do_halt(input logic [3:0] o, input addr_t a);
        @(posedge clk);
        hx <= 1'b1;
        op <= o;
        pc <= a;
        #1 t0 = cyc;
        @(posedge clk);
        hx <= 1'b0;
        #1;
    endtask : do_halt
    task automatic pulse(input int k);
        @(posedge clk);
        if (k == 0) rx <= 1'b1;
        else clr <= 1'b1;
        @(posedge clk);
        rx <= 1'b0;
        clr <= 1'b0;
        #1;
    endtask : pulse
    task automatic raise_irq(input src_vec_t m);
        @(posedge clk);
        raise <= m;
        @(posedge clk);
        raise <= '0;
        #1;
    endtask : raise_irq
    task automatic test_done;
        $display("Checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    // Watchdog against a hang
    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        test_done();
    end

    // Main sequence
    initial begin
        {rst_b, hx, rx, clr, gie, op, pc, permit, raise, sel, cyc} = '0;
        fail_count = 0;
        total_checks = 0;
        seed = 32'h0000_92a8;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        do_halt(4'h2, 12'h0a5);
        chk1(clk_en, 1'b0);
        // Slower intervals must not set the flag within 1 ms
        for (int s = 2; s >= 0; s--) begin
            @(posedge clk);
            sel <= 2'(s);
            repeat (13400) @(posedge clk);
        end
        #1;
        chk1(cflag, 1'b0);
        chk1(halted, 1'b1);
        // 1 ms select: counter is already past its end, flag sets next edge
        @(posedge clk);
        sel <= 2'b11;
        wait_on(2, 4);
        t1 = cyc;
        chk1(halted, 1'b1);
        @(posedge clk);
        #1;
        chk1(halted, 1'b0);
        chk1(resume, 1'b1);
        chka(rpc, 12'h0a5);
        pulse(1);
        chk1(cflag, 1'b0);
        wait_on(2, 41000);
        chkn(cyc - t1, 40000);
        pulse(1);
        // Request without all enables must not release
        do_halt(4'h8, 12'h123);
        raise_irq(6'h08);
        repeat (20) @(posedge clk);
        #1;
        chk1(halted, 1'b1);
        @(posedge clk);
        permit <= 6'h08;
        repeat (20) @(posedge clk);
        #1;
        chk1(take, 1'b0);
        @(posedge clk);
        gie <= 1'b1;
        wait_on(0, 4);
        chka(vec, `HR_VEC_BT1);
        chka({6'h00, ack}, 12'h008);
        chka(ret, 12'h123);
        pulse(0);
        chk1(resume, 1'b1);
        // Pending request before halt, three spare cycles after flag change
        @(posedge clk);
        permit <= 6'h3f;
        raise_irq(6'h20);
        repeat (2) @(posedge clk);
        do_halt(4'h8, 12'h200);
        wait_on(0, 4);
        chkn(cyc - t0, 2);
        chka(vec, `HR_VEC_FCNT);
        pulse(0);
        // Flag set at the halt edge itself is seen one cycle late
        @(posedge clk);
        hx <= 1'b1;
        op <= 4'h8;
        raise <= 6'h02;
        #1 t0 = cyc;
        @(posedge clk);
        hx <= 1'b0;
        raise <= '0;
        #1;
        wait_on(0, 4);
        chkn(cyc - t0, 3);
        chka(vec, `HR_VEC_PIN1);
        pulse(0);
        chk1(resume, 1'b1);
        // Simultaneous pin zero and basic timer 1
        do_halt(4'h8, 12'h300);
        raise_irq(6'h09);
        wait_on(0, 4);
        chka(vec, `HR_VEC_PIN0);
        pulse(0);
        chk1(take, 1'b1);
        chk1(resume, 1'b0);
        chka(vec, `HR_VEC_BT1);
        pulse(0);
        chka(rpc, 12'h300);
        // Each source with random operand, address, permits and delay
        for (int k = 0; k < 6; k++) begin
            r = rnd();
            do_halt({1'b1, 1'b0, r[12], 1'b0}, r[11:0]);
            repeat (r[15:13]) @(posedge clk);
            permit <= r[21:16] | src_vec_t'(1 << k);
            raise_irq(src_vec_t'(1 << k));
            wait_on(0, 12);
            chka(vec, vtab[k]);
            chka({6'h00, ack}, addr_t'(1 << k));
            pulse(0);
            chka(rpc, r[11:0]);
        end
        // Empty operand: only reset ends halt; operand latched
        do_halt(4'h0, 12'h050);
        do_halt(4'hf, 12'h777);
        raise_irq(6'h3f);
        repeat (50) @(posedge clk);
        #1;
        chk1(halted, 1'b1);
        chk1(take, 1'b0);
        chka(ret, 12'h050);
        @(posedge clk);
        rst_b <= 1'b0;
        #1;
        chk1(halted, 1'b0);
        chk1(clk_en, 1'b1);
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        test_done();
    end
endmodule : tb
